// [shared/ipsp_pkg.sv]
`default_nettype none
package ipsp_pkg;
    // Slave addressing
    localparam logic [6:0] ADDR_DEFAULT = 7'h2A;
    localparam logic [7:0] WR_ADDR_BYTE = 8'h54;
    localparam logic [7:0] RD_ADDR_BYTE = 8'h55;
    localparam int ADDR_W = 7;
    // Buffers and packet framing
    localparam int BUF_DEPTH = 22;
    localparam int PTR_W = 5;
    localparam logic [7:0] LEN_MAX = 8'h12;
    localparam logic [7:0] PKT_OVERHEAD = 8'h04;
    localparam logic [PTR_W-1:0] LEN_IDX = 5'h01;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Link and key timing
    localparam int LINK_MAX_HZ = 100000;
    localparam int SYS_CLK_HZ = 20000000;
    localparam int KEY_HOLD_MS = 4000;
    localparam int KEY_HOLD_CYC = KEY_HOLD_MS * (SYS_CLK_HZ / 1000);
    // Bit positions in the system-side synchroniser bank
    localparam int SY_SDA = 0;
    localparam int SY_SCL = 1;
    localparam int SY_WTG = 2;
    localparam int SY_UP = 3;
    localparam int SY_DN = 4;
    localparam int SY_W = 5;
    // Link-side byte engine states
    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_ACK_A, L_WDATA, L_ACK_W, L_RDATA, L_ACK_R
    } ipsp_link_t;
    // System-side packet hand-off states
    typedef enum logic [1:0] {
        S_IDLE, S_FETCH, S_CHECK, S_PEND
    } ipsp_sys_t;
endpackage : ipsp_pkg
`default_nettype wire

// [design/ipsp_mem.sv]
`timescale 1ns/1ns
`default_nettype none
// Two-clock byte buffer, read data registered on the read clock
module ipsp_mem #(
    parameter int W = 8,
    parameter int DEPTH = 22,
    parameter int AW = 5
) (
    // Write side
    input wire logic i_wclk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    // Read side
    input wire logic i_rclk,
    input wire logic [AW-1:0] i_raddr,
    output logic [W-1:0] o_rdata
);
    logic [W-1:0] mem [DEPTH];

    // Storage write
    always_ff @(posedge i_wclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Registered read
    always_ff @(posedge i_rclk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule : ipsp_mem
`default_nettype wire

// [design/ipsp_port.sv]
`timescale 1ns/1ns
`default_nettype none
module ipsp_port import ipsp_pkg::*; #(
    parameter int KEY_HOLD = KEY_HOLD_CYC,
    parameter int DEPTH = BUF_DEPTH
) (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Two-wire link; serial clock is the link clock
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Keys and address display
    input wire logic i_key_up,
    input wire logic i_key_down,
    output logic o_show_addr,
    // Address configuration
    input wire logic i_boot_valid,
    input wire logic [6:0] i_boot_addr,
    input wire logic i_addr_set,
    input wire logic [6:0] i_addr_new,
    output logic [6:0] o_slave_addr,
    // Received packet to foreground
    output logic o_pkt_valid,
    output logic o_pkt_ok,
    output logic [7:0] o_pkt_len,
    output logic [PTR_W-1:0] o_pkt_count,
    input wire logic [PTR_W-1:0] i_pkt_addr,
    output logic [7:0] o_pkt_data,
    input wire logic i_pkt_take,
    // Response from foreground
    input wire logic i_rsp_we,
    input wire logic [PTR_W-1:0] i_rsp_addr,
    input wire logic [7:0] i_rsp_data,
    input wire logic i_rsp_commit,
    input wire logic [PTR_W-1:0] i_rsp_len
);
    localparam logic [PTR_W-1:0] WLAST = PTR_W'(DEPTH - 1);
    localparam logic [31:0] HOLD_END = 32'(KEY_HOLD);

    // Per-bit agreement filter for three-stage synchronisers
    function automatic logic [SY_W-1:0] agree(input logic [SY_W-1:0] q,
                                              input logic [SY_W-1:0] b,
                                              input logic [SY_W-1:0] c);
        agree = ((b ~^ c) & c) | ((b ^ c) & q);
    endfunction : agree

    // ---------------- Link domain ----------------
    ipsp_link_t l_state_r, l_state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [6:0] sh_r, sh_nxt;
    logic rw_r, rw_nxt, ack_r, ack_nxt, lock_r, lock_nxt, wtgl_r, wtgl_nxt;
    logic [PTR_W-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt, len_l_r, len_l_nxt;
    logic [6:0] addr_l_r, addr_l_nxt;
    logic [2:0] csy_r, csy_nxt;
    logic cq_r, cq_nxt, cseen_r, cseen_nxt;
    logic start_tgl_r, start_seen_r, start_new, wbuf_we, sda_oe_nxt;
    logic [7:0] rbuf_q, wbuf_q;
    logic cfg_tgl_r;
    logic [6:0] cfg_addr_r;
    logic [PTR_W-1:0] cfg_len_r;
    ipsp_sys_t s_state_r, s_state_nxt;

    // Start marker: data line falls while clock is high
    always_ff @(negedge i_sda or negedge i_reset_n) begin
        if (!i_reset_n) begin
            start_tgl_r <= 1'b0;
        end else if (i_scl) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    assign start_new = start_tgl_r != start_seen_r;

    // Byte engine next state, sampled on rising serial clock
    always_comb begin
        l_state_nxt = l_state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        rw_nxt = rw_r;
        ack_nxt = ack_r;
        wptr_nxt = wptr_r;
        lock_nxt = lock_r;
        rptr_nxt = rptr_r;
        wtgl_nxt = wtgl_r;
        wbuf_we = 1'b0;
        if (start_new) begin
            l_state_nxt = L_ADDR;
            cnt_nxt = 3'h1;
            sh_nxt = {sh_r[5:0], i_sda};
            wptr_nxt = '0;
            rptr_nxt = '0;
            lock_nxt = 1'b0;
        end else begin
            unique case (l_state_r)
                L_IDLE: begin
                end
                L_ADDR: begin
                    sh_nxt = {sh_r[5:0], i_sda};
                    cnt_nxt = cnt_r + 3'h1;
                    if (cnt_r == BIT_LAST) begin
                        l_state_nxt = L_ACK_A;
                        rw_nxt = i_sda;
                        ack_nxt = sh_r == addr_l_r;
                    end
                end
                L_ACK_A: begin
                    cnt_nxt = '0;
                    if (!ack_r) begin
                        l_state_nxt = L_IDLE;
                    end else if (rw_r) begin
                        l_state_nxt = L_RDATA;
                    end else begin
                        l_state_nxt = L_WDATA;
                    end
                end
                L_WDATA: begin
                    sh_nxt = {sh_r[5:0], i_sda};
                    cnt_nxt = cnt_r + 3'h1;
                    if (cnt_r == BIT_LAST) begin
                        l_state_nxt = L_ACK_W;
                        ack_nxt = !lock_r && (wptr_r != WLAST);
                        if (!lock_r) begin
                            wbuf_we = 1'b1;
                            wtgl_nxt = ~wtgl_r;
                            if (wptr_r == WLAST) begin
                                lock_nxt = 1'b1;
                            end else begin
                                wptr_nxt = wptr_r + 1'b1;
                            end
                        end
                    end
                end
                L_ACK_W: begin
                    l_state_nxt = L_WDATA;
                    cnt_nxt = '0;
                end
                L_RDATA: begin
                    cnt_nxt = cnt_r + 3'h1;
                    if (cnt_r == BIT_LAST) begin
                        l_state_nxt = L_ACK_R;
                    end
                end
                L_ACK_R: begin
                    cnt_nxt = '0;
                    if (i_sda) begin
                        l_state_nxt = L_IDLE;
                    end else begin
                        l_state_nxt = L_RDATA;
                        if (len_l_r > 1 && rptr_r < len_l_r - 1'b1) begin
                            rptr_nxt = rptr_r + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Configuration hand-over from system domain
    always_comb begin
        csy_nxt = {csy_r[1:0], cfg_tgl_r};
        cq_nxt = (csy_r[1] == csy_r[2]) ? csy_r[2] : cq_r;
        cseen_nxt = cq_r;
        addr_l_nxt = (cq_r != cseen_r) ? cfg_addr_r : addr_l_r;
        len_l_nxt = (cq_r != cseen_r) ? cfg_len_r : len_l_r;
    end

    // Link registers; only clock edges and reset move them, so a stopped clock holds all
    always_ff @(posedge i_scl or negedge i_reset_n) begin
        if (!i_reset_n) begin
            l_state_r <= L_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            wptr_r <= '0;
            lock_r <= 1'b0;
            rptr_r <= '0;
            wtgl_r <= 1'b0;
            start_seen_r <= 1'b0;
            csy_r <= '0;
            cq_r <= 1'b0;
            cseen_r <= 1'b0;
            addr_l_r <= ADDR_DEFAULT;
            len_l_r <= '0;
        end else begin
            l_state_r <= l_state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rw_r <= rw_nxt;
            ack_r <= ack_nxt;
            wptr_r <= wptr_nxt;
            lock_r <= lock_nxt;
            rptr_r <= rptr_nxt;
            wtgl_r <= wtgl_nxt;
            start_seen_r <= start_tgl_r;
            csy_r <= csy_nxt;
            cq_r <= cq_nxt;
            cseen_r <= cseen_nxt;
            addr_l_r <= addr_l_nxt;
            len_l_r <= len_l_nxt;
        end
    end

    // Data line drive, changed only while serial clock is low
    always_comb begin
        unique case (l_state_r)
            L_ACK_A, L_ACK_W: sda_oe_nxt = ack_r;
            L_RDATA: sda_oe_nxt = !rbuf_q[BIT_LAST - cnt_r];
            default: sda_oe_nxt = 1'b0;
        endcase
    end

    always_ff @(negedge i_scl or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sda_oe <= 1'b0;
        end else begin
            o_sda_oe <= sda_oe_nxt;
        end
    end

    assign o_sda_o = 1'b0;

    // Write buffer: link writes, foreground reads
    ipsp_mem #(.W(8), .DEPTH(DEPTH), .AW(PTR_W)) u_wbuf (
        .i_wclk(i_scl),
        .i_we(wbuf_we),
        .i_waddr(wptr_r),
        .i_wdata({sh_r, i_sda}),
        .i_rclk(i_clk_sys),
        .i_raddr((s_state_r == S_FETCH) ? LEN_IDX : i_pkt_addr),
        .o_rdata(wbuf_q)
    );

    // Read buffer: foreground writes, link reads
    ipsp_mem #(.W(8), .DEPTH(DEPTH), .AW(PTR_W)) u_rbuf (
        .i_wclk(i_clk_sys),
        .i_we(i_rsp_we),
        .i_waddr(i_rsp_addr),
        .i_wdata(i_rsp_data),
        .i_rclk(i_scl),
        .i_raddr(rptr_nxt),
        .o_rdata(rbuf_q)
    );

    // ---------------- System domain ----------------
    logic [SY_W-1:0] s1_r, s2_r, s3_r, sq_r, sp_r, sq_nxt;
    logic [PTR_W-1:0] wcnt_r, wcnt_nxt, cfg_len_nxt, pcnt_nxt;
    logic [31:0] hold_r, hold_nxt;
    logic [7:0] plen_nxt;
    logic [6:0] cfg_addr_nxt;
    logic boot_done_r, cfg_tgl_nxt, show_nxt, pok_nxt, start_s, stop_s, byte_s;

    assign sq_nxt = agree(sq_r, s2_r, s3_r);
    assign start_s = sp_r[SY_SCL] && sq_r[SY_SCL] && sp_r[SY_SDA] && !sq_r[SY_SDA];
    assign stop_s = sp_r[SY_SCL] && sq_r[SY_SCL] && !sp_r[SY_SDA] && sq_r[SY_SDA];
    assign byte_s = sp_r[SY_WTG] != sq_r[SY_WTG];

    // Packet framing, address config and key hold
    always_comb begin
        s_state_nxt = s_state_r;
        wcnt_nxt = wcnt_r;
        plen_nxt = o_pkt_len;
        pok_nxt = o_pkt_ok;
        pcnt_nxt = o_pkt_count;
        cfg_addr_nxt = cfg_addr_r;
        cfg_len_nxt = cfg_len_r;
        cfg_tgl_nxt = cfg_tgl_r;
        if (start_s) begin
            wcnt_nxt = '0;
        end else if (byte_s && wcnt_r != PTR_W'(DEPTH)) begin
            wcnt_nxt = wcnt_r + 1'b1;
        end
        unique case (s_state_r)
            S_IDLE: if (stop_s && wcnt_r != '0) begin
                s_state_nxt = S_FETCH;
                pcnt_nxt = wcnt_r;
            end
            S_FETCH: s_state_nxt = S_CHECK;
            S_CHECK: begin
                s_state_nxt = S_PEND;
                plen_nxt = wbuf_q;
                pok_nxt = (wbuf_q <= LEN_MAX) && (o_pkt_count > LEN_IDX)
                    && ({3'h0, o_pkt_count} == wbuf_q + PKT_OVERHEAD);
            end
            S_PEND: if (i_pkt_take) begin
                s_state_nxt = S_IDLE;
            end
        endcase
        if (!boot_done_r && i_boot_valid) begin
            cfg_addr_nxt = i_boot_addr;
            cfg_tgl_nxt = ~cfg_tgl_r;
        end else if (i_addr_set) begin
            cfg_addr_nxt = i_addr_new;
            cfg_tgl_nxt = ~cfg_tgl_r;
        end
        if (i_rsp_commit) begin
            cfg_len_nxt = i_rsp_len;
            cfg_tgl_nxt = ~cfg_tgl_r;
        end
        hold_nxt = (sq_r[SY_UP] && sq_r[SY_DN]) ?
            ((hold_r == HOLD_END) ? hold_r : hold_r + 32'h1) : 32'h0;
        show_nxt = hold_nxt == HOLD_END;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_state_r <= S_IDLE;
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            sq_r <= '0;
            sp_r <= '0;
            wcnt_r <= '0;
            o_pkt_len <= '0;
            o_pkt_ok <= 1'b0;
            o_pkt_count <= '0;
            cfg_addr_r <= ADDR_DEFAULT;
            cfg_len_r <= '0;
            cfg_tgl_r <= 1'b0;
            boot_done_r <= 1'b0;
            hold_r <= '0;
            o_show_addr <= 1'b0;
        end else begin
            s_state_r <= s_state_nxt;
            s1_r <= {i_key_down, i_key_up, wtgl_r, i_scl, i_sda};
            s2_r <= s1_r;
            s3_r <= s2_r;
            sq_r <= sq_nxt;
            sp_r <= sq_r;
            wcnt_r <= wcnt_nxt;
            o_pkt_len <= plen_nxt;
            o_pkt_ok <= pok_nxt;
            o_pkt_count <= pcnt_nxt;
            cfg_addr_r <= cfg_addr_nxt;
            cfg_len_r <= cfg_len_nxt;
            cfg_tgl_r <= cfg_tgl_nxt;
            boot_done_r <= 1'b1;
            hold_r <= hold_nxt;
            o_show_addr <= show_nxt;
        end
    end

    assign o_slave_addr = cfg_addr_r;
    assign o_pkt_valid = s_state_r == S_PEND;
    assign o_pkt_data = wbuf_q;

    // ---------------- Checks ----------------
    sequence addr_byte_end_s;
        l_state_r == L_ADDR && cnt_r == BIT_LAST && !start_new;
    endsequence
    sequence last_slot_s;
        l_state_r == L_WDATA && cnt_r == BIT_LAST && !start_new && !lock_r && wptr_r == WLAST;
    endsequence

    addr_match_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        addr_byte_end_s |=> (ack_r == ($past(sh_r) == $past(addr_l_r))) && l_state_r == L_ACK_A)
        else $error("address acknowledge does not follow match");
    full_nak_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        last_slot_s |=> !ack_r && lock_r && l_state_r == L_ACK_W)
        else $error("last free slot not refused");
    discard_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        lock_r && !start_new |-> !wbuf_we ##1 (l_state_r != L_ACK_W || !ack_r))
        else $error("byte stored or acknowledged after full");
    rewind_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        start_new |=> wptr_r == '0 && rptr_r == '0 && l_state_r == L_ADDR)
        else $error("pointers not rewound on start");
    read_end_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        l_state_r == L_ACK_R && i_sda && !start_new |=> l_state_r == L_IDLE)
        else $error("read not ended by final refusal");
    hold_last_a: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        l_state_r == L_ACK_R && !i_sda && !start_new && len_l_r != '0
        && rptr_r == len_l_r - 1'b1 |=> $stable(rptr_r))
        else $error("read pointer ran past last byte");
    pkt_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(o_pkt_valid) && o_pkt_ok |-> o_pkt_len <= LEN_MAX)
        else $error("packet length out of range accepted");
    pkt_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        s_state_r == S_IDLE && stop_s && wcnt_r != '0 |-> ##3 o_pkt_valid)
        else $error("packet not handed over after stop");
    addr_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        boot_done_r && i_addr_set |=> o_slave_addr == $past(i_addr_new))
        else $error("new slave address not taken");
    show_addr_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(o_show_addr) |-> $past(hold_r) == HOLD_END - 32'h1 && sq_r[SY_UP] && sq_r[SY_DN])
        else $error("address shown without full key hold");
endmodule : ipsp_port
`default_nettype wire

// [bench/ipsp_master.sv]
`timescale 1ns/1ns
`default_nettype none
// Two-wire bus master; serial clock stands high outside frames
module ipsp_master (
    // Link pins, data is open drain
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda
);
    // Kept slow enough for the system-side stop detector
    int half = 310;
    int hold = 0;
    initial begin
        o_scl = 1'h1;
        o_sda_low = 1'h0;
    end
    // One clock pulse; data moves well clear of the falling edge
    task automatic bit_cyc(input logic low, output logic seen);
        #(half / 3);
        o_sda_low = low;
        #(half - half / 3 + hold);
        o_scl = 1'h1;
        #(half / 2);
        seen = i_sda;
        #(half - half / 2);
        o_scl = 1'h0;
    endtask : bit_cyc
    // Start or repeated start; only the master opens a frame
    task automatic start();
        #(half / 3);
        o_sda_low = 1'h0;
        #half;
        o_scl = 1'h1;
        #(2 * half);
        o_sda_low = 1'h1;
        #(2 * half);
        o_scl = 1'h0;
    endtask : start
    // Stop, then the clock stands still
    task automatic stop();
        #(half / 3);
        o_sda_low = 1'h1;
        #half;
        o_scl = 1'h1;
        #(2 * half);
        o_sda_low = 1'h0;
        #(2 * half);
    endtask : stop
    // Byte out, most significant bit first, answer on ninth clock
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(!b[i], s);
        end
        bit_cyc(1'h0, ack);
    endtask : wbyte
    // Byte in; the final one is answered with not-acknowledge
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'h0, b[i]);
        end
        bit_cyc(!last, s);
    endtask : rbyte
endmodule : ipsp_master
`default_nettype wire

// [bench/test_ipsp_port.sv]
`timescale 1ns/1ns
`default_nettype none
module test_ipsp_port import ipsp_pkg::*; ();
    logic clk = 1'h0;
    logic rst_n;
    logic scl, m_low, sda_oe, sda_o, show, pkt_valid, pkt_ok, ack_m;
    logic key_up = 1'h0, key_dn = 1'h0, boot_v = 1'h0, addr_set = 1'h0;
    logic take = 1'h0, rsp_we = 1'h0, commit = 1'h0;
    logic [6:0] boot_a = 7'h00, addr_new = 7'h00, slave_a;
    logic [4:0] pkt_addr = 5'h00, rsp_addr = 5'h00, rsp_len = 5'h00, pkt_count;
    logic [7:0] rsp_data = 8'h00, pkt_len, pkt_data;
    int n_fail = 0, compares = 0, cyc = 0;
    // Pulled-up data line
    wire sda = !(m_low | (sda_oe & !sda_o));
    ipsp_port #(.KEY_HOLD(20), .DEPTH(BUF_DEPTH)) u_ipsp_port (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_key_up(key_up), .i_key_down(key_dn),
        .o_show_addr(show), .i_boot_valid(boot_v), .i_boot_addr(boot_a),
        .i_addr_set(addr_set), .i_addr_new(addr_new), .o_slave_addr(slave_a),
        .o_pkt_valid(pkt_valid), .o_pkt_ok(pkt_ok), .o_pkt_len(pkt_len),
        .o_pkt_count(pkt_count), .i_pkt_addr(pkt_addr), .o_pkt_data(pkt_data),
        .i_pkt_take(take), .i_rsp_we(rsp_we), .i_rsp_addr(rsp_addr),
        .i_rsp_data(rsp_data), .i_rsp_commit(commit), .i_rsp_len(rsp_len));
    ipsp_master u_ipsp_master (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
    // System clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] val(input int i, input logic [7:0] len);
        return (i == 1) ? len : 8'hA0 + 8'(i);
    endfunction : val
    // Read probe, one byte read when acknowledged, returns the address answer bit
    task automatic probe(input logic [6:0] a, output logic ack);
        logic [7:0] b;
        u_ipsp_master.start();
        u_ipsp_master.wbyte({a, 1'h1}, ack);
        if (ack === 1'h0) u_ipsp_master.rbyte(1'h1, b);
        u_ipsp_master.stop();
    endtask : probe
    // Whole packet in one write frame, then checked on the foreground side
    task automatic wr_pkt(input int n, input logic [7:0] len);
        logic ack;
        int k;
        int t;
        u_ipsp_master.start();
        u_ipsp_master.wbyte(WR_ADDR_BYTE, ack);
        chk("write address ack", 8'h00, {7'h00, ack});
        for (int i = 0; i < n; i++) begin
            u_ipsp_master.wbyte(val(i, len), ack);
            chk("data ack", {7'h00, i >= BUF_DEPTH - 1}, {7'h00, ack});
        end
        u_ipsp_master.stop();
        k = (n < BUF_DEPTH) ? n : BUF_DEPTH;
        t = 0;
        while (pkt_valid !== 1'h1 && t < 40) begin
            @(posedge clk) #1;
            t++;
        end
        chk("packet valid", 8'h01, {7'h00, pkt_valid});
        chk("packet length", len, pkt_len);
        chk("packet count", 8'(k), {3'h0, pkt_count});
        chk("packet ok", {7'h00, len <= LEN_MAX && k == len + 4}, {7'h00, pkt_ok});
        for (int j = 0; j < k; j++) begin
            @(posedge clk) pkt_addr <= 5'(j);
            @(posedge clk) #1;
            chk("stored byte", val(j, len), pkt_data);
        end
        @(posedge clk) take <= 1'h1;
        @(posedge clk) take <= 1'h0;
        @(posedge clk) #1;
        chk("valid after take", 8'h00, {7'h00, pkt_valid});
    endtask : wr_pkt
    // Response read past its end, then rewound by a repeated start
    task automatic t_read();
        logic ack;
        logic [7:0] b;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            rsp_we <= 1'h1;
            rsp_addr <= 5'(i);
            rsp_data <= 8'h11 * 8'(i + 1);
        end
        @(posedge clk);
        rsp_we <= 1'h0;
        commit <= 1'h1;
        rsp_len <= 5'h03;
        @(posedge clk);
        commit <= 1'h0;
        repeat (20) @(posedge clk);
        u_ipsp_master.start();
        u_ipsp_master.wbyte(RD_ADDR_BYTE, ack);
        chk("read address ack", 8'h00, {7'h00, ack});
        for (int i = 0; i < 5; i++) begin
            u_ipsp_master.rbyte(i == 4, b);
            chk("read byte", 8'h11 * 8'((i < 3 ? i : 2) + 1), b);
        end
        #1;
        chk("released after final nak", 8'h00, {7'h00, sda_oe});
        u_ipsp_master.start();
        u_ipsp_master.wbyte(RD_ADDR_BYTE, ack);
        u_ipsp_master.rbyte(1'h1, b);
        chk("read after repeated start", 8'h11, b);
        u_ipsp_master.stop();
    endtask : t_read
    // Address moved to both range ends and back
    task automatic t_addr();
        logic ack;
        logic [6:0] prev;
        prev = ADDR_DEFAULT;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            addr_set <= 1'h1;
            addr_new <= (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : ADDR_DEFAULT;
            @(posedge clk);
            addr_set <= 1'h0;
            repeat (20) @(posedge clk);
            chk("slave address", {1'h0, addr_new}, {1'h0, slave_a});
            probe(addr_new, ack);
            chk("new address ack", 8'h00, {7'h00, ack});
            probe(prev, ack);
            chk("old address ack", 8'h01, {7'h00, ack});
            prev = addr_new;
        end
    endtask : t_addr
    // Both keys must be held the full count
    task automatic t_keys();
        @(posedge clk) key_up <= 1'h1;
        repeat (40) @(posedge clk);
        #1;
        chk("show with one key", 8'h00, {7'h00, show});
        @(posedge clk) key_dn <= 1'h1;
        repeat (10) @(posedge clk);
        #1;
        chk("show before hold", 8'h00, {7'h00, show});
        repeat (30) @(posedge clk);
        #1;
        chk("show after hold", 8'h01, {7'h00, show});
        @(posedge clk) key_up <= 1'h0;
        repeat (10) @(posedge clk);
        #1;
        chk("show after release", 8'h00, {7'h00, show});
        @(posedge clk) key_dn <= 1'h0;
    endtask : t_keys
    // Reboot with a stored boot address
    task automatic t_boot();
        @(posedge clk);
        boot_v <= 1'h1;
        boot_a <= 7'h33;
        rst_n <= 1'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        repeat (10) @(posedge clk);
        #1;
        chk("boot address", 8'h33, {1'h0, slave_a});
        probe(7'h33, ack_m);
        chk("boot address ack", 8'h00, {7'h00, ack_m});
    endtask : t_boot
    // Main sequence
    initial begin
        rst_n <= 1'h0; // Falling from unknown gives every async reset an edge
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        repeat (10) @(posedge clk);
        #1;
        chk("reset address", {1'h0, ADDR_DEFAULT}, {1'h0, slave_a});
        wr_pkt(4, 8'h00);
        wr_pkt(22, LEN_MAX);
        wr_pkt(24, LEN_MAX);
        wr_pkt(23, 8'h13);
        wr_pkt(5, 8'h02);
        probe(7'h2B, ack_m);
        chk("miss address ack", 8'h01, {7'h00, ack_m});
        t_read();
        t_addr();
        t_keys();
        u_ipsp_master.half = 5000;
        u_ipsp_master.hold = 20000;
        wr_pkt(4, 8'h00);
        u_ipsp_master.half = 310;
        u_ipsp_master.hold = 0;
        t_boot();
        give_verdict();
    end
endmodule : test_ipsp_port
`default_nettype wire
